/* File: core/gef_params.svh */
// Purpose: constants of the gpio and error flag logic
// Assumes: 100 MHz clk
// Notes: register indices are the 4-bit spi register pointers
`ifndef GEF_PARAMS_SVH
`define GEF_PARAMS_SVH
// register pointers
`define GEF_REG_GAIN 4'h0
`define GEF_REG_CPHASE 4'h2
`define GEF_REG_ERR 4'h4
`define GEF_REG_PINOUT 4'h6
`define GEF_REG_DIR 4'h8
`define GEF_REG_ECSEN 4'h9
`define GEF_REG_SUPCFG 4'hB
`define GEF_REG_SFR 4'hC
// reset values and magic data
`define GEF_RST_BYTE 8'h00
`define GEF_ERR_CLR_ALL 8'hFF
// error status bit positions
`define GEF_ERR_OVV 0
`define GEF_ERR_GAIN 1
`define GEF_ERR_OUT 2
`define GEF_ERR_CLAMP 3
`define GEF_ERR_CRC 5
// config bit positions
`define GEF_SUP_LSB 0
`define GEF_SUP_MSB 3
`define GEF_LTD_BIT 6
`define GEF_CRC_EN_BIT 7
`define GEF_MUX_LSB 0
`define GEF_MUX_MSB 2
// command byte codes
`define GEF_OP_WRITE 2'b01
`define GEF_OP_RDECS 2'b10
`define GEF_OP_ECS 2'b11
`define GEF_ECS_PIN_MAX 3'h6
// timing
`define GEF_CLK_NS 10
`define GEF_SUP_UNIT_NS 1000
`define GEF_SUP_UNIT_CYC ((`GEF_SUP_UNIT_NS + `GEF_CLK_NS - 1) / `GEF_CLK_NS)
`endif

/* File: core/gef_pkg.sv */
// Purpose: types of the gpio and error flag logic
// Assumes: nothing
// Notes: constants live in gef_params.svh
package gef_pkg;
	typedef enum logic [2:0] {
		GEF_ST_CMD = 3'b001,
		GEF_ST_ECSW = 3'b010,
		GEF_ST_ECS = 3'b100
	} gef_state_e;
	typedef struct packed {
		logic clamp;
		logic out_stage;
		logic gain_ovl;
		logic overvolt;
	} gef_sens_s;
	typedef logic [6:0] gef_pins_t;
endpackage

/* File: core/gef_core.sv */
// Purpose: spi register slave, error flags and seven gpio pins
// Assumes: spi pins and analog sensor levels are asynchronous to clk
// Notes: checksum byte is not checked here; its verdict arrives on crc_fail
`include "gef_params.svh"

module gef_core
	import gef_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// spi slave pins
	input wire logic spi_cs_b,
	input wire logic spi_sclk,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	// general purpose pins
	input wire gef_pins_t gpio_in,
	output gef_pins_t gpio_out,
	output gef_pins_t gpio_oe,
	// analog sensors and buffer
	input wire gef_sens_s sens_raw,
	input wire logic buffer_active,
	input wire logic oscillator_in,
	input wire logic crc_fail,
	// controls to the analog side
	output logic [7:0] gain_ctrl,
	output logic [7:0] switch_ctrl,
	output logic buffer_trigger,
	output logic buffer_trigger_in,
	output logic sync_in_a
);
	////////////////////////////////////////////////////////////////
	// synchronisers: first stage read only by second
	logic [2:0] spi_m_r, spi_s_r;
	gef_pins_t gpio_m_r, gpio_s_r;
	logic [5:0] an_m_r, an_s_r;
	logic sclk_d_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			spi_m_r <= 3'h7;
			spi_s_r <= 3'h7;
			gpio_m_r <= 7'h00;
			gpio_s_r <= 7'h00;
			an_m_r <= 6'h00;
			an_s_r <= 6'h00;
			sclk_d_r <= 1'b1;
		end else begin
			spi_m_r <= {spi_cs_b, spi_sclk, spi_sdi};
			spi_s_r <= spi_m_r;
			gpio_m_r <= gpio_in;
			gpio_s_r <= gpio_m_r;
			an_m_r <= {oscillator_in, buffer_active, sens_raw};
			an_s_r <= an_m_r;
			sclk_d_r <= spi_s_r[1];
		end
	end
	wire cs_hi = spi_s_r[2];
	wire sclk_s = spi_s_r[1];
	wire sdi_s = spi_s_r[0];
	// oscillator is slow beside clk, so two flops cost only a little phase
	wire osc_s = an_s_r[5];
	wire buffer_active_s = an_s_r[4];
	wire [3:0] sens_s = an_s_r[3:0];
	wire sclk_fall = sclk_d_r & ~sclk_s;
	wire sclk_rise = ~sclk_d_r & sclk_s;

	////////////////////////////////////////////////////////////////
	// registers and spi state
	logic [7:0] gain_r, cph_r, err_r, pout_r, dir_r, ecsen_r, sup_r, sfr_r, sw_r;
	logic [7:0] shift_r, cmd_r, rd_r;
	logic [2:0] bit_r, ecs_idx_r;
	logic [1:0] byte_r;
	logic sdo_r, trig_r;
	gef_state_e st_r, st_nxt;

	// register read decode, used only for the read data
	function automatic logic [7:0] reg_rd(input logic [3:0] a);
		case (a)
			`GEF_REG_GAIN: reg_rd = gain_r;
			`GEF_REG_CPHASE: reg_rd = cph_r;
			`GEF_REG_ERR: reg_rd = err_r;
			`GEF_REG_PINOUT: reg_rd = {1'b0, gpio_s_r};
			`GEF_REG_DIR: reg_rd = dir_r;
			`GEF_REG_ECSEN: reg_rd = ecsen_r;
			`GEF_REG_SUPCFG: reg_rd = sup_r;
			`GEF_REG_SFR: reg_rd = sfr_r;
			4'hE: reg_rd = sw_r;
			default: reg_rd = 8'h00;
		endcase
	endfunction

	// byte assembly on falling sclk; ignored while extended select owns the bus
	wire in_cmd = (st_r == GEF_ST_CMD) & ~cs_hi;
	wire [7:0] byte_nxt = {shift_r[6:0], sdi_s};
	wire byte_done = in_cmd & sclk_fall & (bit_r == 3'h7);
	wire cmd_done = byte_done & (byte_r == 2'h0);
	wire is_ecs = (byte_nxt[7:6] == `GEF_OP_ECS) & ~byte_nxt[4] & ~byte_nxt[3];
	wire ecs_ok = is_ecs & (byte_nxt[2:0] <= `GEF_ECS_PIN_MAX) & ecsen_r[byte_nxt[2:0]];
	wire is_trig = byte_nxt[6] & byte_nxt[5]; // write and select only; reserved 00 stays inert
	wire wr_done = byte_done & (byte_r == 2'h1) & (cmd_r[7:6] == `GEF_OP_WRITE);
	wire [3:0] wr_a = cmd_r[3:0];
	wire [7:0] clr_mask = (wr_done & (wr_a == `GEF_REG_ERR)) ? byte_nxt : 8'h00;
	wire ltd = sup_r[`GEF_LTD_BIT];
	wire crc_en = sup_r[`GEF_CRC_EN_BIT];

	// next state of the command engine
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			GEF_ST_CMD: begin
				if (cmd_done & ecs_ok) begin
					st_nxt = cph_r[byte_nxt[2:0]] ? GEF_ST_ECS : GEF_ST_ECSW;
				end
			end
			GEF_ST_ECSW: begin
				if (cs_hi) begin
					st_nxt = GEF_ST_CMD;
				end else if (sclk_rise) begin
					st_nxt = GEF_ST_ECS;
				end
			end
			GEF_ST_ECS: begin
				if (cs_hi) begin
					st_nxt = GEF_ST_CMD;
				end
			end
			default: st_nxt = GEF_ST_CMD;
		endcase
	end

	// spi shift, byte counting; byte 2 is checksum or dummy, then next command
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= GEF_ST_CMD;
			shift_r <= 8'h00;
			cmd_r <= 8'h00;
			rd_r <= 8'h00;
			bit_r <= 3'h0;
			byte_r <= 2'h0;
			ecs_idx_r <= 3'h0;
			trig_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			trig_r <= cmd_done & is_trig;
			if (cs_hi) begin
				bit_r <= 3'h0;
				byte_r <= 2'h0;
			end else if (in_cmd & sclk_fall) begin
				shift_r <= byte_nxt;
				bit_r <= bit_r + 3'h1;
				if (bit_r == 3'h7) begin
					byte_r <= (byte_r == 2'h2) ? 2'h0 : byte_r + 2'h1;
				end
			end
			if (cmd_done) begin
				cmd_r <= byte_nxt;
				rd_r <= reg_rd(byte_nxt[3:0]);
				ecs_idx_r <= byte_nxt[2:0];
			end
		end
	end

	// sdo launched on rising sclk during the data byte
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sdo_r <= 1'b0;
		end else if (in_cmd & sclk_rise & (byte_r == 2'h1)) begin
			sdo_r <= rd_r[~bit_r];
		end
	end
	assign spi_sdo = sdo_r;
	assign spi_sdo_oe = in_cmd & (byte_r == 2'h1) & (cmd_r[7:4] == 4'h8);

	// register writes; pins default to inputs with a zero output latch
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gain_r <= `GEF_RST_BYTE;
			cph_r <= `GEF_RST_BYTE;
			pout_r <= `GEF_RST_BYTE;
			dir_r <= `GEF_RST_BYTE;
			ecsen_r <= `GEF_RST_BYTE;
			sup_r <= `GEF_RST_BYTE;
			sfr_r <= `GEF_RST_BYTE;
			sw_r <= `GEF_RST_BYTE;
		end else if (wr_done) begin
			case (wr_a)
				`GEF_REG_GAIN: gain_r <= byte_nxt;
				`GEF_REG_CPHASE: cph_r <= byte_nxt;
				`GEF_REG_PINOUT: pout_r <= byte_nxt;
				`GEF_REG_DIR: dir_r <= byte_nxt;
				`GEF_REG_ECSEN: ecsen_r <= byte_nxt;
				`GEF_REG_SUPCFG: sup_r <= byte_nxt;
				`GEF_REG_SFR: sfr_r <= byte_nxt;
				4'hE: sw_r <= byte_nxt;
				default: ;
			endcase
		end
	end
	assign gain_ctrl = gain_r;
	assign switch_ctrl = sw_r;
	assign buffer_trigger = trig_r;

	////////////////////////////////////////////////////////////////
	// suppression delay: sensor must stay active for the whole window
	logic [10:0] cnt_r [4];
	wire [10:0] sup_lim = 11'(sup_r[`GEF_SUP_MSB:`GEF_SUP_LSB] * `GEF_SUP_UNIT_CYC);
	logic [3:0] filt;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			filt[i] = sens_s[i] & ~buffer_active_s & (cnt_r[i] >= sup_lim);
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 4; i++) cnt_r[i] <= 11'h000;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (!sens_s[i] || buffer_active_s) cnt_r[i] <= 11'h000;
				else if (cnt_r[i] < sup_lim) cnt_r[i] <= cnt_r[i] + 11'h001;
			end
		end
	end

	// live error vector; sensor struct order is clamp,out,gain,overvolt
	logic [7:0] live;
	always_comb begin
		live = 8'h00;
		live[`GEF_ERR_OVV] = filt[0];
		live[`GEF_ERR_GAIN] = filt[1];
		live[`GEF_ERR_OUT] = filt[2];
		live[`GEF_ERR_CLAMP] = filt[3];
		live[`GEF_ERR_CRC] = crc_fail & crc_en;
	end
	// set wins over a clear arriving in the same cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) err_r <= `GEF_RST_BYTE;
		else if (ltd) err_r <= live;
		else err_r <= (err_r & ~clr_mask) | live;
	end
	wire err_any = |err_r;

	////////////////////////////////////////////////////////////////
	// pin muxing: extended select, then special function, then latch
	wire [2:0] mux_a = gain_r[`GEF_MUX_MSB:`GEF_MUX_LSB];
	wire [6:0] fn_sel = {sfr_r[6:5], 1'b0, sfr_r[3:0]};
	wire [6:0] fn_val = {osc_s, buffer_active_s, 1'b0, err_any, mux_a[2:0]};
	wire ecs_on = (st_r == GEF_ST_ECS);
	always_comb begin
		for (int n = 0; n < 7; n++) begin
			if (ecsen_r[n]) gpio_out[n] = ~(ecs_on & (ecs_idx_r == 3'(n)));
			else if (fn_sel[n]) gpio_out[n] = fn_val[n];
			else gpio_out[n] = pout_r[n];
		end
	end
	assign gpio_oe = dir_r[6:0];
	assign buffer_trigger_in = sfr_r[4] & gpio_s_r[4];
	assign sync_in_a = sfr_r[7] & gpio_s_r[2];

	////////////////////////////////////////////////////////////////
	// checks
	chk_pins_reset: assert property (@(posedge clk) disable iff (!rst_b)
		!$past(rst_b) |-> gpio_oe == 7'h00) else $error("pins not inputs after reset");
	chk_flag_hold: assert property (@(posedge clk) disable iff (!rst_b)
		!ltd && clr_mask == 8'h00 |=> (err_r & $past(err_r)) == $past(err_r))
		else $error("latched flag lost");
	chk_ltd_follow: assert property (@(posedge clk) disable iff (!rst_b)
		ltd |=> err_r == $past(live)) else $error("flags not following live");
	chk_buffer_active_quiet: assert property (@(posedge clk) disable iff (!rst_b)
		buffer_active_s && !crc_fail && !ltd |=> (err_r & ~$past(err_r)) == 8'h00)
		else $error("flag set during buffer active");
	chk_crc_gate: assert property (@(posedge clk) disable iff (!rst_b)
		!crc_en && !err_r[`GEF_ERR_CRC] |=> !err_r[`GEF_ERR_CRC])
		else $error("checksum flag set while disabled");
	chk_sup_delay: assert property (@(posedge clk) disable iff (!rst_b)
		sup_r[3:0] != 4'h0 && !ltd && $rose(sens_s[0]) && !err_r[0] |-> ##1 !err_r[0])
		else $error("suppression delay bypassed");
	chk_err_pin: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_r[3] && !ecsen_r[3] |-> gpio_out[3] == (err_r != 8'h00))
		else $error("error pin mismatch");
	chk_mux_drive: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_r[1] && !ecsen_r[1] |-> gpio_out[1] == gain_r[1]) else $error("mux pin wrong");
	chk_ecs_release: assert property (@(posedge clk) disable iff (!rst_b)
		cs_hi |=> !ecs_on) else $error("extended select held after cs");
	chk_sdo_quiet: assert property (@(posedge clk) disable iff (!rst_b)
		st_r != GEF_ST_CMD |-> !spi_sdo_oe) else $error("sdo driven in ecs");
	chk_ecs_phase: assert property (@(posedge clk) disable iff (!rst_b)
		cmd_done && ecs_ok && cph_r[byte_nxt[2:0]] |=> ecs_on)
		else $error("phase 1 select late");
	cov_ecs: cover property (@(posedge clk) disable iff (!rst_b) $rose(ecs_on));
	cov_flag: cover property (@(posedge clk) disable iff (!rst_b) $rose(err_any));
	cov_clear: cover property (@(posedge clk) disable iff (!rst_b) clr_mask != 8'h00);
	cov_read: cover property (@(posedge clk) disable iff (!rst_b) $rose(spi_sdo_oe));
endmodule

/* File: verif/gef_spi_host.sv */
// Purpose: spi host model for the register port
// Assumes: sclk idles high; the device samples sdi on falling sclk
// Notes: each sclk phase is 6 clk so the device synchronisers keep up
module gef_spi_host (
	// clock
	input wire logic clk,
	// spi wires
	output logic cs_b,
	output logic sclk,
	output logic sdi,
	input wire logic sdo
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_b = 1'b1;
		sclk = 1'b1;
		sdi = 1'b1;
	end
	////////////////////////////////////////
	// one byte msb first; sdi moves with rising sclk, far from the sampling fall
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sdi = tx[i];
			repeat (6) @(posedge clk);
			#1;
			rx[i] = sdo;
			sclk = 1'b0;
			repeat (6) @(posedge clk);
			#1;
			sclk = 1'b1;
		end
	endtask
	// margins around chip select; stop also ends any extended select
	task automatic start();
		cs_b = 1'b0;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic stop();
		repeat (4) @(posedge clk);
		#1;
		cs_b = 1'b1;
		repeat (6) @(posedge clk);
		#1;
	endtask
endmodule

/* File: verif/testbench.sv */
// Purpose: self-checking bench for gef_core
// Assumes: sup unit of 100 clk, all registers reset to zero
// Notes: seed 8430 drives the random register and pin values
module testbench
	import gef_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic buffer_active = 1'b0;
	logic crc_fail = 1'b0;
	logic osc = 1'b0;
	logic bt_in, sy_in;
	logic cs_b, sclk, sdi, spi_sdo, spi_sdo_oe, buffer_trigger;
	gef_pins_t gpio_in, gpio_out, gpio_oe;
	gef_sens_s sens_raw = '0;
	logic [7:0] gain_ctrl, switch_ctrl, rx, v;
	tri1 sdo_line;
	int miscompares = 0, tests_run = 0, seed = 8430, trig_cnt = 0;
	logic [3:0] addrs [8] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'h9, 4'hB, 4'hC, 4'h5};
	// pulled-up sdo: a floating device output reads high, never a stale bit
	assign sdo_line = spi_sdo_oe ? spi_sdo : 1'bz;
	always #5 clk = ~clk;
	always @(posedge clk) if (buffer_trigger === 1'b1) trig_cnt++;
	gef_core i_gef_core (.clk(clk), .rst_b(rst_b), .spi_cs_b(cs_b), .spi_sclk(sclk),
		.spi_sdi(sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .gpio_in(gpio_in),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .sens_raw(sens_raw),
		.buffer_active(buffer_active), .oscillator_in(osc), .crc_fail(crc_fail),
		.gain_ctrl(gain_ctrl), .switch_ctrl(switch_ctrl), .buffer_trigger(buffer_trigger),
		.buffer_trigger_in(bt_in), .sync_in_a(sy_in));
	gef_spi_host host_m (.clk(clk), .cs_b(cs_b), .sclk(sclk), .sdi(sdi), .sdo(sdo_line));
	////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
		tests_run++;
		if (seen !== want) begin
			miscompares++;
			$display("CHECK FAILED t=%0t %s seen %h want %h", $time, what, seen, want);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// write: 01T0 aaaa then data, chip select ends the command
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic t = 1'b0);
		host_m.start();
		host_m.xbyte({2'b01, t, 1'b0, a}, rx);
		host_m.xbyte(d, rx);
		host_m.stop();
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		host_m.start();
		host_m.xbyte({4'h8, a}, d);
		host_m.xbyte(8'h00, d);
		host_m.stop();
	endtask
	// status bit of sensor i matches its struct position
	function automatic logic [7:0] err_bit(input int i);
		return 8'h01 << i;
	endfunction
	task automatic sense(input int i, input int cyc);
		sens_raw[i] = 1'b1;
		repeat (cyc) @(posedge clk);
		#1 sens_raw[i] = 1'b0;
		repeat (150) @(posedge clk);
		#1;
	endtask
	////////////////////////////////////////
	// watchdog: the run needs about 20k clk, twice that means a hang
	initial begin
		#400_000;
		miscompares++;
		give_verdict();
	end
	initial begin
		gpio_in = 7'($random(seed));
		repeat (3) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		check(gpio_oe, 8'h00, "oe after reset");
		check(gpio_out, 8'h00, "out after reset");
		foreach (addrs[k]) begin
			rd(addrs[k], v);
			check(v, 8'h00, "reset or unmapped read");
		end
		// random read-back of the writable registers other than error 4, pinout 6 and switches E
		for (int k = 0; k < 7; k++) begin
			if (k != 2) begin
				v = 8'($random(seed));
				wr(addrs[k], v);
				rd(addrs[k], rx);
				check(rx, v, "read back");
				if (addrs[k] == 4'h8) check(gpio_oe, v[6:0], "direction");
				if (addrs[k] == 4'h0) check(gain_ctrl, v, "gain");
				wr(addrs[k], 8'h00);
			end
		end
		v = 8'($random(seed));
		wr(4'hE, v);
		check(switch_ctrl, v, "switches");
		wr(4'h8, 8'h02);
		check(gpio_out[1], 1'b0, "latch default");
		wr(4'h6, 8'h02);
		check(gpio_out[1], 1'b1, "latch drive");
		// gain write with trigger first, then direction and routing of mux and error out
		wr(4'h0, 8'h05, 1'b1);
		check(trig_cnt, 1, "buffer trigger");
		// reserved opcode with the trigger bit must stay inert
		host_m.start();
		host_m.xbyte(8'h20, rx);
		host_m.xbyte(8'h00, rx);
		host_m.stop();
		check(trig_cnt, 1, "reserved op no trigger");
		wr(4'h8, 8'h0B);
		wr(4'hC, 8'h0B);
		check(gpio_out[1:0], 2'b01, "mux 5");
		wr(4'h0, 8'h06);
		check(gpio_out[1:0], 2'b10, "mux 6");
		wr(4'hB, 8'h01);
		for (int i = 0; i < 4; i++) begin
			sense(i, 60);
			rd(4'h4, v);
			check(v, 8'h00, "short pulse");
			sense(i, 150);
			check(gpio_out[3], 1'b1, "error out");
			rd(4'h4, v);
			check(v, err_bit(i), "flag latched");
			wr(4'h4, 8'hFF);
			rd(4'h4, v);
			check(v, 8'h00, "cleared");
			check(gpio_out[3], 1'b0, "error out low");
		end
		wr(4'hB, 8'h41);
		sens_raw.overvolt = 1'b1;
		repeat (150) @(posedge clk);
		#1;
		rd(4'h4, v);
		check(v, 8'h01, "live set");
		sense(0, 0);
		rd(4'h4, v);
		check(v, 8'h00, "live clear");
		wr(4'hB, 8'h01);
		buffer_active = 1'b1;
		sense(1, 150);
		buffer_active = 1'b0;
		rd(4'h4, v);
		check(v, 8'h00, "buffer masks");
		for (int c = 0; c < 2; c++) begin
			wr(4'hB, {c[0], 7'h01});
			crc_fail = 1'b1;
			@(posedge clk);
			#1 crc_fail = 1'b0;
			rd(4'h4, v);
			check(v, c ? 8'h20 : 8'h00, "checksum flag");
		end
		wr(4'h4, 8'hFF);
		// special functions: osc and busy out on 6 and 5, pins 4 and 2 feed in
		gpio_in = 7'($random(seed)) | 7'h14;
		osc = 1'b1;
		buffer_active = 1'b1;
		wr(4'h8, 8'h6B);
		wr(4'hC, 8'hF0);
		check(gpio_out[6:5], 2'b11, "osc and busy out");
		check({sy_in, bt_in}, 2'b11, "trigger and sync in");
		rd(4'h6, v);
		check(v, {1'b0, gpio_in}, "pin levels");
		osc = 1'b0;
		buffer_active = 1'b0;
		wr(4'hC, 8'h0B);
		wr(4'h8, 8'h0B);
		check({sy_in, bt_in}, 2'b00, "inputs unrouted");
		check(gpio_out[6:5], 2'b00, "latch again");
		// extended select on pin 1, both clock phases, then a refused pin
		wr(4'h9, 8'h02);
		check(gpio_out[1], 1'b1, "select idle");
		for (int p = 0; p < 2; p++) begin
			wr(4'h2, {6'h00, p[0], 1'b0});
			host_m.start();
			host_m.xbyte(8'hC1, rx);
			repeat (8) @(posedge clk);
			#1;
			check(gpio_out[1], 1'b0, "select on");
			host_m.xbyte(8'h40, rx);
			host_m.xbyte(8'hAA, rx);
			check(spi_sdo_oe, 1'b0, "sdo floats");
			host_m.stop();
			check(gpio_out[1], 1'b1, "select off");
			rd(4'h0, v);
			check(v, 8'h06, "traffic ignored");
		end
		host_m.start();
		host_m.xbyte(8'hC7, rx);
		repeat (8) @(posedge clk);
		#1;
		check(gpio_out[1], 1'b1, "pin 7 refused");
		host_m.stop();
		give_verdict();
	end
endmodule
